// ==== tb/tb_top.sv ====
// Bench for the engine control block: APB master, line model, self checks.
// Assumes the register map of usc_pkg; every transfer waits on pready.
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, setup_token = 1'h0, pending_event = 1'h0, se0_req = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, t;
    logic [15:0] pp_toggle = 16'h0, ppi;
    logic pready, pslverr, dp_in, dm_in, dp_out, dm_out, d_oe, sie_clk_en, transceiver_en, full_speed;
    logic pullup_en, resume_drive, pkt_dis, e;
    logic [1:0] pp_mode;
    int err_total = 0, n_checks = 0, cyc = 0;

    always #50 clk = ~clk;

    usc_sie_ctrl #(.NUM_PP(16)) i_usc_sie_ctrl (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out), .dm_out(dm_out), .d_oe(d_oe), .setup_token(setup_token),
        .pending_event(pending_event), .pp_toggle(pp_toggle), .pingpong_pointer_indicator(ppi),
        .sie_clk_en(sie_clk_en), .transceiver_en(transceiver_en), .full_speed(full_speed), .pullup_en(pullup_en),
        .resume_drive(resume_drive), .packet_disable_flag(pkt_dis), .pingpong_mode_field(pp_mode));

    usc_host_model i_usc_host_model (.se0_req(se0_req), .full_spd(full_speed), .pullup_on(pullup_en),
        .d_oe(d_oe), .dp_out(dp_out), .dm_out(dm_out), .dp_line(dp_in), .dm_line(dm_in));

    function automatic logic [31:0] cfg(input logic [1:0] m, input logic fs, input logic pu, input logic eye);
        return {24'h0, eye, 2'h0, pu, 1'h0, fs, m};
    endfunction

    function automatic logic [31:0] ctl(input logic pr, input logic en, input logic res, input logic sus);
        return {25'h0, pr, 2'h0, en, res, sus, 1'h0};
    endfunction

    task automatic test_done;
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(r, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pulse(input logic [15:0] tg, input logic st);
        @(posedge clk);
        pp_toggle <= tg;
        setup_token <= st;
        @(posedge clk);
        pp_toggle <= 16'h0;
        setup_token <= 1'h0;
        @(negedge clk);
    endtask

    task automatic eye_check(input int div);
        int i;
        i = 0;
        while (d_oe !== 1'h1 && i < 20) begin
            tick(1);
            i++;
        end
        for (i = 0; i < 24; i++) begin
            chk({d_oe, dp_out, dm_out}, {1'h1, (i / div) % 2 == 1, (i / div) % 2 == 0});
            tick(1);
        end
    endtask

    initial begin
        void'($urandom(59));
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        rd(usc_pkg::ADDR_CONTROL, 32'h0);
        rd(usc_pkg::ADDR_CONFIG, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(usc_pkg::ADDR_CONFIG, cfg(m[1:0], m[0], 1'h1, 1'h0));
            rd(usc_pkg::ADDR_CONFIG, cfg(m[1:0], m[0], 1'h1, 1'h0));
            chk(pp_mode, m[1:0]);
            chk(full_speed, m[0]);
            chk(pullup_en, 1'h0);
        end
        // Configure fully before attach
        wr(usc_pkg::ADDR_CONFIG, cfg(2'h2, 1'h1, 1'h1, 1'h0));
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0));
        chk({transceiver_en, pullup_en, sie_clk_en}, 3'h7);
        t = $urandom | 32'h1;
        pulse(t[15:0], 1'h0);
        chk(ppi, t[15:0]);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h1, 1'h1, 1'h0, 1'h0));
        pulse(16'hffff, 1'h0);
        chk(ppi, 16'h0);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0));
        t = $urandom | 32'h1;
        pulse(t[15:0], 1'h0);
        chk(ppi, t[15:0]);
        wr(usc_pkg::ADDR_CONTROL, 32'h0);
        chk({transceiver_en, pullup_en}, 2'h0);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0));
        tick(1);
        chk(ppi, 16'h0);
        pulse(16'h0, 1'h1);
        chk(pkt_dis, 1'h1);
        @(posedge clk);
        pending_event <= 1'h1;
        rd(usc_pkg::ADDR_EVENT, 32'h1);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0) | 32'h10);
        rd(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0) | 32'h10);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0));
        chk(pkt_dis, 1'h0);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0) | 32'h10);
        chk(pkt_dis, 1'h0);
        @(posedge clk);
        se0_req <= 1'h1;
        pending_event <= 1'h0;
        tick(3);
        rd(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0) | 32'h20);
        rd(usc_pkg::ADDR_EVENT, 32'h0);
        @(posedge clk);
        se0_req <= 1'h0;
        tick(3);
        rd(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0));
        // Resume held only briefly here; full length is firmware's duty
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h1, 1'h0));
        tick(2);
        chk({resume_drive, d_oe, dp_out, dm_out}, 4'hd);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h1, 1'h1));
        tick(2);
        chk({sie_clk_en, resume_drive, d_oe}, 3'h0);
        wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0));
        for (int s = 0; s < 2; s++) begin
            wr(usc_pkg::ADDR_CONTROL, 32'h0);
            wr(usc_pkg::ADDR_CONFIG, cfg({s[0], s[0]}, s[0], 1'h0, 1'h1));
            tick(3);
            chk(d_oe, 1'h0);
            wr(usc_pkg::ADDR_CONTROL, ctl(1'h0, 1'h1, 1'h0, 1'h0));
            eye_check(s[0] ? usc_pkg::FS_DIV : usc_pkg::LS_DIV);
            pulse(16'hffff, 1'h0);
            chk(ppi, {{14{s[0]}}, 2'h0});
        end
        // Reset in mid-run while the eye pattern is driving
        @(posedge clk);
        reset <= 1'h1;
        tick(3);
        @(posedge clk);
        reset <= 1'h0;
        tick(2);
        chk({d_oe, pullup_en, transceiver_en, pkt_dis, ppi}, 20'h0);
        rd(usc_pkg::ADDR_CONFIG, 32'h0);
        rd(usc_pkg::ADDR_CONTROL, 32'h0);
        test_done();
    end
endmodule // tb_top

// ==== tb/usc_host_model.sv ====
// Host side of the data lines: pull-downs, device pull-up, SE0 on request.
// Assumes the device output enable is high while the device drives.
`timescale 1ns/1ns
module usc_host_model (
    input wire logic se0_req,
    input wire logic full_spd,
    input wire logic pullup_on,
    input wire logic d_oe,
    input wire logic dp_out,
    input wire logic dm_out,
    output logic dp_line,
    output logic dm_line
);
    // Device wins when driving; else host SE0 or the pulled-up idle J
    assign dp_line = d_oe ? dp_out : (!se0_req && pullup_on && full_spd);
    assign dm_line = d_oe ? dm_out : (!se0_req && pullup_on && !full_spd);
endmodule // usc_host_model

// ==== verilog/usc_pkg.sv ====
// Package for the USB engine control and configuration block.
// Assumes APB with 32-bit data and one clock at 10 MHz.
package usc_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_EVENT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    // Control register fields
    localparam int CTL_RESUME = 2;
    localparam int CTL_SUSPEND = 1;
    localparam int CTL_PP_RESET = 6;
    localparam int CTL_ENABLE = 3;
    localparam int CTL_PKT_DIS = 4;
    localparam int CTL_SE0 = 5;
    // Config register fields
    localparam int CFG_PP_LSB = 0;
    localparam int CFG_FS = 2;
    localparam int CFG_PULLUP = 4;
    localparam int CFG_EYE = 7;
    // Event register (hardware event inputs kept as status)
    localparam int EVT_SETUP = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int NUM_PP = 16;
    // Bit time enables: full speed 12 Mb/s, low speed 1.5 Mb/s, at 10 MHz clock
    localparam int CLK_HZ = 10_000_000;
    localparam int FS_BIT_HZ = 12_000_000;
    localparam int LS_BIT_HZ = 1_500_000;
    localparam int FS_DIV = (CLK_HZ / FS_BIT_HZ) < 1 ? 1 : (CLK_HZ / FS_BIT_HZ);
    localparam int LS_DIV = (CLK_HZ / LS_BIT_HZ) < 1 ? 1 : (CLK_HZ / LS_BIT_HZ);
    typedef enum logic [1:0] {
        USC_PP_NONE = 2'b00,
        USC_PP_EP0_OUT = 2'b01,
        USC_PP_ALL = 2'b10,
        USC_PP_ALL_BUT_EP0 = 2'b11
    } usc_pp_mode_e;
endpackage : usc_pkg

// ==== verilog/usc_pp_bank.sv ====
`timescale 1ns/1ns
// Ping-pong pointer indicator bank, one flop per buffer descriptor pair.
// Assumes toggle strobes from the engine's buffer handling.
module usc_pp_bank #(
    parameter int N = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear_all,
    input wire logic [N-1:0] toggle,
    input wire logic [N-1:0] use_pp,
    output logic [N-1:0] indicator
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ptr
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    indicator[i] <= 1'b0;
                end else if (clear_all) begin
                    indicator[i] <= 1'b0;
                end else if (toggle[i] && use_pp[i]) begin
                    indicator[i] <= ~indicator[i];
                end
            end
        end
    endgenerate
endmodule // usc_pp_bank

// ==== verilog/usc_sie_ctrl.sv ====
`timescale 1ns/1ns
// Control and configuration of a USB serial interface engine.
// Assumes APB master, synchronous pin inputs, one 10 MHz clock.
// Function
// [RQ1] Status bit shows single-ended zero on the data lines.
// [RQ2] Setting enable activates engine and clears all ping-pong indicators.
// [RQ3] Enable also switches on the internal pull-ups: soft attach.
// [RQ4] Firmware supplies clock and configures before setting enable.
// [RQ5] Firmware waits for PLL ready before setting enable.
// [RQ6] Pointer reset holds pointers even; firmware clears it; ignored without ping-pong.
// [RQ7] SETUP token sets packet disable; core can only clear it.
// [RQ8] Pending transaction events stay visible while packets are disabled.
// [RQ9] Resume bit drives resume signaling; firmware holds it 10 ms.
// [RQ10] Suspend gates engine clock; stays attached with idle outputs.
// [RQ11] Firmware sets suspend after idle, clears after activity.
// [RQ12] Speed, transceiver and pull-up set only during setup.
// [RQ13] Transceiver enabled with module enable; full speed when selected.
// [RQ14] Pull-ups follow pull-up enable, only while enabled and configured.
// [RQ15] Ping-pong scheme chosen by the mode field.
// [RQ16] Eye test transmits repeating J-K, K-J at full speed; code uses the configured speed.
// [RQ17] Eye output only while enabled, using configured speed.
// [RQ18] Firmware never enables eye test on a live bus.
// [RQ19] Self-powered designs keep module off until bus supply valid.
// [RQ20] Full-speed select clear means low-speed operation.
module usc_sie_ctrl #(
    parameter int NUM_PP = usc_pkg::NUM_PP
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dp_in,
    input wire logic dm_in,
    output logic dp_out,
    output logic dm_out,
    output logic d_oe,
    input wire logic setup_token,
    input wire logic pending_event,
    input wire logic [NUM_PP-1:0] pp_toggle,
    output logic [NUM_PP-1:0] pingpong_pointer_indicator,
    output logic sie_clk_en,
    output logic transceiver_en,
    output logic full_speed,
    output logic pullup_en,
    output logic resume_drive,
    output logic packet_disable_flag,
    output logic [1:0] pingpong_mode_field
);
    logic [7:0] ctl_reg;
    logic [7:0] cfg_reg;
    logic se0_reg;
    logic pkt_dis_reg;
    logic dp_reg, dm_reg, oe_reg;
    logic [7:0] div_reg;
    logic phase_reg;
    logic enable_rise;
    logic prev_en_reg;

    wire module_enable = ctl_reg[usc_pkg::CTL_ENABLE];
    wire low_power_suspend = ctl_reg[usc_pkg::CTL_SUSPEND];
    wire resume_bit = ctl_reg[usc_pkg::CTL_RESUME];
    wire pingpong_pointer_reset = ctl_reg[usc_pkg::CTL_PP_RESET];
    wire full_speed_select = cfg_reg[usc_pkg::CFG_FS];
    wire pullup_enable = cfg_reg[usc_pkg::CFG_PULLUP];
    wire eye_pattern_enable = cfg_reg[usc_pkg::CFG_EYE];
    wire [1:0] pp_mode = cfg_reg[usc_pkg::CFG_PP_LSB +: 2];

    wire access = psel && penable;
    wire wr = access && pwrite;
    wire wr_ctl = wr && (paddr == usc_pkg::ADDR_CONTROL);
    wire wr_cfg = wr && (paddr == usc_pkg::ADDR_CONFIG);
    wire mapped = (paddr == usc_pkg::ADDR_CONTROL) || (paddr == usc_pkg::ADDR_CONFIG) ||
                  (paddr == usc_pkg::ADDR_EVENT) || (paddr == usc_pkg::ADDR_STATUS);
    wire eye_active = eye_pattern_enable && module_enable; // RQ17
    wire [7:0] bit_div = full_speed_select ? 8'(usc_pkg::FS_DIV) : 8'(usc_pkg::LS_DIV); // RQ20
    wire bit_tick = (div_reg == 8'h00);

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Read mux registered on setup phase so data stands in access phase
    logic [31:0] rd_next;
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (paddr)
            usc_pkg::ADDR_CONTROL: begin
                rd_next[7:0] = ctl_reg;
                rd_next[usc_pkg::CTL_SE0] = se0_reg; // RQ1
                rd_next[usc_pkg::CTL_PKT_DIS] = pkt_dis_reg;
            end
            usc_pkg::ADDR_CONFIG: rd_next[7:0] = cfg_reg;
            usc_pkg::ADDR_EVENT: rd_next[usc_pkg::EVT_SETUP] = pending_event; // RQ8
            usc_pkg::ADDR_STATUS: rd_next[NUM_PP-1:0] = pingpong_pointer_indicator;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_next;
        end
    end

    // Control bits; SE0 and packet-disable bits are not stored here
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl_reg <= usc_pkg::CONTROL_RESET;
        end else if (wr_ctl) begin
            ctl_reg <= pwdata[7:0] & ~(8'h01 << usc_pkg::CTL_SE0) & ~(8'h01 << usc_pkg::CTL_PKT_DIS);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= usc_pkg::CONFIG_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= pwdata[7:0];
        end
    end

    // Set wins over a clear in the same cycle; core may only clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pkt_dis_reg <= 1'b0;
        end else if (setup_token && module_enable && !low_power_suspend) begin
            pkt_dis_reg <= 1'b1; // RQ7
        end else if (wr_ctl && !pwdata[usc_pkg::CTL_PKT_DIS]) begin
            pkt_dis_reg <= 1'b0; // RQ7
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            se0_reg <= 1'b0;
            prev_en_reg <= 1'b0;
        end else begin
            se0_reg <= module_enable && !dp_in && !dm_in; // RQ1
            prev_en_reg <= module_enable;
        end
    end

    assign enable_rise = module_enable && !prev_en_reg;

    wire pp_in_use = pp_mode != usc_pkg::USC_PP_NONE;
    logic [NUM_PP-1:0] pp_use;
    always_comb begin
        pp_use = '0;
        unique case (pp_mode) // RQ15
            usc_pkg::USC_PP_NONE: pp_use = '0;
            usc_pkg::USC_PP_EP0_OUT: pp_use[0] = 1'b1;
            usc_pkg::USC_PP_ALL: pp_use = '1;
            usc_pkg::USC_PP_ALL_BUT_EP0: pp_use = {{(NUM_PP-2){1'b1}}, 2'b00};
        endcase
    end

    wire pp_clear = enable_rise || (pingpong_pointer_reset && pp_in_use); // RQ2 RQ6

    usc_pp_bank #(
        .N(NUM_PP)
    ) u_pp (
        .clk(clk),
        .reset(reset),
        .clear_all(pp_clear),
        .toggle(pp_toggle & {NUM_PP{module_enable && !low_power_suspend && !pkt_dis_reg}}),
        .use_pp(pp_use),
        .indicator(pingpong_pointer_indicator)
    );

    // Bit-rate divider for eye pattern signaling only; resume drives a steady K
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_reg <= 8'h00;
            phase_reg <= 1'b0;
        end else if (!eye_active) begin
            // Preload so the first symbol lasts a full bit time
            div_reg <= bit_div - 8'h01;
            phase_reg <= 1'b0;
        end else if (bit_tick) begin
            div_reg <= bit_div - 8'h01;
            phase_reg <= ~phase_reg;
        end else begin
            div_reg <= div_reg - 8'h01;
        end
    end

    // J is D+ high at full speed, D- high at low speed; K the reverse
    wire j_dp = full_speed_select;
    logic dp_next, dm_next, oe_next;
    always_comb begin
        dp_next = 1'b0;
        dm_next = 1'b0;
        oe_next = 1'b0;
        if (low_power_suspend) begin
            oe_next = 1'b0; // RQ10
        end else if (eye_active) begin
            oe_next = 1'b1; // RQ16
            dp_next = (phase_reg ^ full_speed_select) ? ~j_dp : j_dp; // RQ16
            dm_next = ~dp_next;
        end else if (resume_bit && module_enable) begin
            oe_next = 1'b1; // RQ9
            dp_next = ~j_dp;
            dm_next = j_dp;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dp_reg <= 1'b0;
            dm_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            dp_reg <= dp_next;
            dm_reg <= dm_next;
            oe_reg <= oe_next;
        end
    end

    assign dp_out = dp_reg;
    assign dm_out = dm_reg;
    assign d_oe = oe_reg;
    assign sie_clk_en = module_enable && !low_power_suspend; // RQ10
    assign transceiver_en = module_enable; // RQ13
    assign full_speed = full_speed_select; // RQ13 RQ20
    assign pullup_en = module_enable && pullup_enable; // RQ3 RQ14
    assign resume_drive = resume_bit && module_enable && !low_power_suspend; // RQ9
    assign packet_disable_flag = pkt_dis_reg;
    assign pingpong_mode_field = pp_mode; // RQ15

    property p_pkt_set;
        @(posedge clk) disable iff (reset)
        (setup_token && module_enable && !low_power_suspend) |=> packet_disable_flag;
    endproperty
    a_pkt_set: assert property (p_pkt_set) else $error("setup token did not set packet disable"); // RQ7

    property p_pkt_hold;
        @(posedge clk) disable iff (reset)
        (packet_disable_flag && !wr_ctl) |=> packet_disable_flag;
    endproperty
    a_pkt_hold: assert property (p_pkt_hold) else $error("packet disable dropped without a write"); // RQ7

    property p_pkt_noset;
        @(posedge clk) disable iff (reset)
        (!packet_disable_flag && !setup_token) |=> !packet_disable_flag;
    endproperty
    a_pkt_noset: assert property (p_pkt_noset) else $error("packet disable set without a setup token"); // RQ7

    property p_pp_clear;
        @(posedge clk) disable iff (reset)
        enable_rise |=> (pingpong_pointer_indicator == '0);
    endproperty
    a_pp_clear: assert property (p_pp_clear) else $error("pointers not cleared on enable"); // RQ2

    property p_pp_rst;
        @(posedge clk) disable iff (reset)
        (pingpong_pointer_reset && pp_in_use) [*2] |-> (pingpong_pointer_indicator == '0);
    endproperty
    a_pp_rst: assert property (p_pp_rst) else $error("pointer reset not holding even"); // RQ6

    property p_pullup;
        @(posedge clk) disable iff (reset)
        (wr_ctl && !pwdata[usc_pkg::CTL_ENABLE]) |=> !pullup_en && !transceiver_en;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up active without enable"); // RQ14

    property p_suspend_idle;
        @(posedge clk) disable iff (reset)
        $rose(low_power_suspend) |=> !d_oe && !sie_clk_en;
    endproperty
    a_suspend_idle: assert property (p_suspend_idle) else $error("outputs not idle in suspend"); // RQ10

    property p_eye_drive;
        @(posedge clk) disable iff (reset)
        (eye_active && !low_power_suspend) [*2] |-> d_oe && (dp_out != dm_out);
    endproperty
    a_eye_drive: assert property (p_eye_drive) else $error("eye pattern not driven"); // RQ16

    property p_eye_toggle;
        @(posedge clk) disable iff (reset)
        (eye_active && !low_power_suspend && bit_tick) ##1 (eye_active && !low_power_suspend)
            |=> $changed(dp_out);
    endproperty
    a_eye_toggle: assert property (p_eye_toggle) else $error("eye pattern did not alternate"); // RQ16

    property p_eye_off;
        @(posedge clk) disable iff (reset)
        (!module_enable && !resume_bit) |=> !d_oe;
    endproperty
    a_eye_off: assert property (p_eye_off) else $error("driving while disabled"); // RQ17

    property p_se0;
        @(posedge clk) disable iff (reset)
        (module_enable && !dp_in && !dm_in) |=> se0_reg;
    endproperty
    a_se0: assert property (p_se0) else $error("single-ended zero not reported"); // RQ1
endmodule // usc_sie_ctrl
